// *** rtl/bsup_pkg.sv ***
// Summary of operation
// R1: High and low fire both on for the no-combustion time causes lockout.
// R2: Timeout mode wait: a stalled monitored step waits with no warning.
// R3: Timeout mode alarm: warn after no-combustion time, clear and advance when satisfied.
// R4: Timeout mode lockout: lockout when a monitored step stalls for no-combustion time.
// R5: Timeout handling applies only to air off, air on and prepurge wait steps.
// R6: Restart prepurge option acts only with prepurge enabled, after a stop in combustion.
// R7: Restart option every time: full prepurge before every restart.
// R8: Restart option cancel: skip prepurge within reignition time, else prepurge.
// R9: Restart option lockout: skip prepurge within reignition time, else lockout.
// R10: Software should program a non-zero postpurge time with cancel or lockout restart.
// R11: Low fire stop is only available when pilot start is the run request.
// R12: Low fire stop off: pilot start off stops the burner immediately.
// R13: Low fire stop on: drive motor to low fire, stop once low fire is seen.
// R14: Low fire not reached within the combustion error time causes lockout.
// R15: Residual mode none: postpurge lasts exactly the postpurge time, flame ignored.
// R16: Residual mode continue: postpurge extends while residual flame is seen.
// R17: Limited and lockout modes extend, then stop blower at no-combustion time; lockout locks.
// R18: Software should set no-combustion time no shorter than both postpurge times.
// R19: Air pressure answerback joins the prepurge conditions only when enabled.
// R20: Lockout latches with outputs safe until the lockout reset input is applied.
package bsup_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int AW = 8;
    localparam int DW = 16;
    localparam logic [AW-1:0] OFS_CFG = 8'h00;
    localparam logic [AW-1:0] OFS_T_NOCOMB = 8'h04;
    localparam logic [AW-1:0] OFS_T_COMB = 8'h08;
    localparam logic [AW-1:0] OFS_T_POST = 8'h0C;
    localparam logic [AW-1:0] OFS_T_LOPOST = 8'h10;
    localparam logic [AW-1:0] OFS_T_REIGN = 8'h14;
    localparam logic [AW-1:0] OFS_T_PREPURGE = 8'h18;
    localparam logic [AW-1:0] OFS_STATUS = 8'h1C;
    localparam logic [DW-1:0] CFG_RST = 16'h0000;
    localparam logic [DW-1:0] T_NOCOMB_RST = 16'h0064;
    localparam logic [DW-1:0] T_COMB_RST = 16'h0064;
    localparam logic [DW-1:0] T_POST_RST = 16'h0032;
    localparam logic [DW-1:0] T_LOPOST_RST = 16'h0032;
    localparam logic [DW-1:0] T_REIGN_RST = 16'h0064;
    localparam logic [DW-1:0] T_PREPURGE_RST = 16'h0032;

    typedef enum logic [1:0] {
        TMO_WAIT = 2'h0,
        TMO_ALARM = 2'h1,
        TMO_LOCK = 2'h2
    } bsup_tmo_t;

    typedef enum logic [1:0] {
        RST_EVERY = 2'h0,
        RST_CANCEL = 2'h1,
        RST_LOCK = 2'h2
    } bsup_rstm_t;

    typedef enum logic [1:0] {
        RES_NONE = 2'h0,
        RES_CONT = 2'h1,
        RES_LIMIT = 2'h2,
        RES_LOCK = 2'h3
    } bsup_res_t;

    // Configuration word, most significant field first.
    typedef struct packed {
        logic [4:0] spare;
        logic ans_en;
        bsup_res_t res_mode;
        logic lfs_en;
        logic pilot_use;
        logic pp_en;
        bsup_rstm_t rst_mode;
        logic [0:0] rsvd;
        bsup_tmo_t tmo_mode;
    } bsup_cfg_t;

    // Field inputs, all asynchronous to mclk.
    typedef struct packed {
        logic hi_fire;
        logic lo_fire;
        logic air_sw;
        logic flame;
        logic pilot_start;
        logic air_ans;
        logic start_req;
        logic lock_reset;
    } bsup_pins_t;
endpackage : bsup_pkg

// *** rtl/bsup_timer.sv ***
`timescale 1ns/100ps
module bsup_timer
    import bsup_pkg::*;
(
    // Clock and control.
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // Count control.
    input wire logic clr,
    input wire logic tick,
    // Elapsed time in ticks.
    output logic [DW-1:0] cnt
);
    // Saturates so a long stall never wraps back below a threshold.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt <= '0;
        end else if (ce) begin
            if (clr) begin
                cnt <= '0;
            end else if (tick && cnt != 16'hFFFF) begin
                cnt <= cnt + 16'h0001;
            end
        end
    end
endmodule : bsup_timer

// *** rtl/bsup_top.sv ***
`timescale 1ns/100ps
module bsup_top
    import bsup_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // Register port.
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // Field inputs.
    input wire bsup_pins_t pins,
    // Burner outputs.
    output logic blower_on,
    output logic burner_run,
    output logic motor_low,
    output logic warn,
    output logic lockout
);
    typedef enum {
        ST_IDLE,
        ST_AIR_OFF,
        ST_AIR_ON,
        ST_PP_WAIT,
        ST_PURGE,
        ST_RUN,
        ST_LOW_STOP,
        ST_POST,
        ST_LOCK
    } bsup_st_t;

    bsup_st_t state_r;
    bsup_st_t state_nxt;
    bsup_pins_t pin_s1_r;
    bsup_pins_t pin_r;
    bsup_cfg_t cfg_r;
    logic [DW-1:0] t_nocomb_r;
    logic [DW-1:0] t_comb_r;
    logic [DW-1:0] t_post_r;
    logic [DW-1:0] t_lopost_r;
    logic [DW-1:0] t_reign_r;
    logic [DW-1:0] t_pre_r;
    logic [31:0] div_r;
    logic tick;
    logic [DW-1:0] st_cnt;
    logic [DW-1:0] hl_cnt;
    logic [DW-1:0] rs_cnt;
    logic comb_seen_r;
    logic warn_r;
    logic blower_r;
    logic run_r;
    logic motor_low_r;
    logic lock_r;
    logic res_lock_r;
    logic run_req;
    logic lfs_act;
    logic monitored;
    logic adv;
    logic step_late;
    logic hl_bad;
    logic lock_now;
    logic purge_cond;
    logic [DW-1:0] rdata_r;

    function automatic logic reached(input logic [DW-1:0] cnt, input logic [DW-1:0] lim);
        reached = cnt >= lim;
    endfunction : reached

    // Field pins are metastable-prone; only the second stage is read.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_s1_r <= '0;
            pin_r <= '0;
        end else if (ce) begin
            pin_s1_r <= pins;
            pin_r <= pin_s1_r;
        end
    end

    // Judgment times are held in 0.1 s ticks.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_r <= '0;
        end else if (ce) begin
            if (div_r >= 32'(TICK_CYCLES - 1)) begin
                div_r <= '0;
            end else begin
                div_r <= div_r + 32'h0000_0001;
            end
        end
    end
    assign tick = (div_r == 32'(TICK_CYCLES - 1));

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_r <= bsup_cfg_t'(CFG_RST);
            t_nocomb_r <= T_NOCOMB_RST;
            t_comb_r <= T_COMB_RST;
            t_post_r <= T_POST_RST;
            t_lopost_r <= T_LOPOST_RST;
            t_reign_r <= T_REIGN_RST;
            t_pre_r <= T_PREPURGE_RST;
        end else if (ce && reg_wr) begin
            unique case (reg_addr)
                OFS_CFG: cfg_r <= bsup_cfg_t'(reg_wdata);
                OFS_T_NOCOMB: t_nocomb_r <= reg_wdata;
                OFS_T_COMB: t_comb_r <= reg_wdata;
                OFS_T_POST: t_post_r <= reg_wdata;
                OFS_T_LOPOST: t_lopost_r <= reg_wdata;
                OFS_T_REIGN: t_reign_r <= reg_wdata;
                OFS_T_PREPURGE: t_pre_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else if (ce) begin
            rdata_r <= '0;
            if (reg_rd) begin
                unique case (reg_addr)
                    OFS_CFG: rdata_r <= cfg_r;
                    OFS_T_NOCOMB: rdata_r <= t_nocomb_r;
                    OFS_T_COMB: rdata_r <= t_comb_r;
                    OFS_T_POST: rdata_r <= t_post_r;
                    OFS_T_LOPOST: rdata_r <= t_lopost_r;
                    OFS_T_REIGN: rdata_r <= t_reign_r;
                    OFS_T_PREPURGE: rdata_r <= t_pre_r;
                    OFS_STATUS: rdata_r <= {3'h0, comb_seen_r, pin_r, warn_r, lock_r,
                        blower_r, run_r};
                    default: rdata_r <= '0;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_r;

    bsup_timer u_step_tmr (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .clr(state_nxt != state_r),
        .tick(tick),
        .cnt(st_cnt)
    );

    bsup_timer u_hilo_tmr (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .clr(!(pin_r.hi_fire && pin_r.lo_fire)),
        .tick(tick),
        .cnt(hl_cnt)
    );

    // Measures time since the run step ended, for the reignition decision.
    bsup_timer u_restart_tmr (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .clr(state_r == ST_RUN),
        .tick(tick),
        .cnt(rs_cnt)
    );

    always_comb begin
        run_req = cfg_r.pilot_use ? pin_r.pilot_start : pin_r.start_req;
        lfs_act = cfg_r.lfs_en && cfg_r.pilot_use; // [R11]
        purge_cond = pin_r.air_sw && pin_r.lo_fire && (pin_r.air_ans || !cfg_r.ans_en); // [R19]
        monitored = (state_r == ST_AIR_OFF) || (state_r == ST_AIR_ON) ||
            (state_r == ST_PP_WAIT); // [R5]
        unique case (state_r)
            ST_AIR_OFF: adv = !pin_r.air_sw;
            ST_AIR_ON: adv = pin_r.air_sw;
            ST_PP_WAIT: adv = purge_cond;
            default: adv = 1'b0;
        endcase
        step_late = monitored && !adv && reached(st_cnt, t_nocomb_r);
        hl_bad = pin_r.hi_fire && pin_r.lo_fire && reached(hl_cnt, t_nocomb_r); // [R1]
        lock_now = hl_bad || (step_late && cfg_r.tmo_mode == TMO_LOCK); // [R4]
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (run_req) begin
                    if (!cfg_r.pp_en) begin
                        state_nxt = ST_RUN;
                    end else if (comb_seen_r && cfg_r.rst_mode == RST_CANCEL) begin
                        state_nxt = reached(rs_cnt, t_reign_r) ? ST_AIR_OFF : ST_RUN; // [R8]
                    end else if (comb_seen_r && cfg_r.rst_mode == RST_LOCK) begin
                        state_nxt = reached(rs_cnt, t_reign_r) ? ST_LOCK : ST_RUN; // [R9]
                    end else begin
                        state_nxt = ST_AIR_OFF; // [R6] [R7]
                    end
                end
            end
            ST_AIR_OFF, ST_AIR_ON, ST_PP_WAIT: begin
                // A stalled step simply holds here in wait and alarm modes.
                if (!run_req) begin
                    state_nxt = ST_POST;
                end else if (adv) begin // [R2] [R3]
                    state_nxt = (state_r == ST_AIR_OFF) ? ST_AIR_ON :
                        (state_r == ST_AIR_ON) ? ST_PP_WAIT : ST_PURGE;
                end
            end
            ST_PURGE: begin
                if (!run_req) begin
                    state_nxt = ST_POST;
                end else if (reached(st_cnt, t_pre_r)) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!run_req) begin
                    if (lfs_act) begin
                        state_nxt = ST_LOW_STOP; // [R13]
                    end else begin
                        state_nxt = cfg_r.pp_en ? ST_POST : ST_IDLE; // [R12]
                    end
                end
            end
            ST_LOW_STOP: begin
                if (pin_r.lo_fire) begin
                    state_nxt = cfg_r.pp_en ? ST_POST : ST_IDLE; // [R13]
                end else if (reached(st_cnt, t_comb_r)) begin
                    state_nxt = ST_LOCK; // [R14]
                end
            end
            ST_POST: begin
                unique case (cfg_r.res_mode)
                    RES_NONE: begin
                        if (reached(st_cnt, t_post_r)) begin
                            state_nxt = ST_IDLE; // [R15]
                        end
                    end
                    RES_CONT: begin
                        if (reached(st_cnt, t_post_r) && !pin_r.flame) begin
                            state_nxt = ST_IDLE; // [R16]
                        end
                    end
                    RES_LIMIT, RES_LOCK: begin
                        if (reached(st_cnt, t_post_r) && !pin_r.flame) begin
                            state_nxt = ST_IDLE;
                        end else if (reached(st_cnt, t_nocomb_r)) begin
                            state_nxt = (cfg_r.res_mode == RES_LOCK) ? ST_LOCK : ST_IDLE; // [R17]
                        end
                    end
                endcase
            end
            ST_LOCK: begin
                if (pin_r.lock_reset) begin
                    state_nxt = ST_IDLE; // [R20]
                end
            end
        endcase
        if (lock_now && state_r != ST_LOCK) begin
            state_nxt = ST_LOCK; // [R1] [R4]
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // A restart counts as a reignition only after real combustion.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            comb_seen_r <= 1'b0;
        end else if (ce) begin
            if (state_r == ST_LOCK || !cfg_r.pp_en) begin
                comb_seen_r <= 1'b0;
            end else if (state_r == ST_RUN) begin
                comb_seen_r <= 1'b1; // [R6]
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            warn_r <= 1'b0;
        end else if (ce) begin
            warn_r <= step_late && cfg_r.tmo_mode == TMO_ALARM; // [R3]
        end
    end

    // A postpurge lockout has already spent its blower time.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            res_lock_r <= 1'b0;
        end else if (ce) begin
            if (state_r != ST_LOCK) begin
                res_lock_r <= (state_r == ST_POST) && (state_nxt == ST_LOCK); // [R17]
            end
        end
    end

    // In lockout the blower purges for the lockout postpurge time, unless lockout came from postpurge, then all stop.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            blower_r <= 1'b0;
            run_r <= 1'b0;
            motor_low_r <= 1'b0;
            lock_r <= 1'b0;
        end else if (ce) begin
            lock_r <= (state_r == ST_LOCK); // [R20]
            // The burner fires on while the motor winds back to low fire.
            run_r <= (state_r == ST_RUN) || (state_r == ST_LOW_STOP); // [R13]
            motor_low_r <= (state_r == ST_PP_WAIT) || (state_r == ST_LOW_STOP); // [R13]
            unique case (state_r)
                ST_AIR_ON, ST_PP_WAIT, ST_PURGE, ST_RUN, ST_LOW_STOP: blower_r <= 1'b1;
                ST_POST: blower_r <= 1'b1; // [R16] [R17]
                ST_LOCK: begin
                    // Lockout postpurge, unless the blower time ran out in postpurge.
                    blower_r <= !res_lock_r && !reached(st_cnt, t_lopost_r); // [R17] [R20]
                end
                default: blower_r <= 1'b0;
            endcase
        end
    end

    assign blower_on = blower_r;
    assign burner_run = run_r;
    assign motor_low = motor_low_r;
    assign warn = warn_r;
    assign lockout = lock_r;
endmodule : bsup_top

// *** verif/bsup_field.sv ***
`timescale 1ns/100ps
module bsup_field (
    // Clock and actuator commands.
    input wire logic mclk,
    input wire logic blower_on,
    input wire logic motor_low,
    // Fault controls: a held air switch, a forced low fire switch.
    input wire logic air_hold,
    input wire logic [1:0] lo_mode,
    // Switch contacts.
    output logic air_sw,
    output logic lo_fire
);
    int air_cnt = 0;
    int lo_cnt = 0;
    logic lo_pos = 1'b0;
    initial air_sw = 1'b0;
    // Both switches lag their actuators, as real contacts do.
    always @(posedge mclk) begin
        air_cnt <= (air_sw == blower_on || air_hold) ? 0 : air_cnt + 1;
        if (air_cnt >= 2) begin
            air_sw <= blower_on;
        end
        lo_cnt <= (lo_pos == motor_low) ? 0 : lo_cnt + 1;
        if (lo_cnt >= 2) begin
            lo_pos <= motor_low;
        end
    end
    assign lo_fire = (lo_mode == 2'h1) ? 1'b1 : (lo_mode == 2'h2) ? 1'b0 : lo_pos;
endmodule : bsup_field

// *** verif/bsup_chk.sv ***
`timescale 1ns/100ps
module bsup_chk
    import bsup_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    // Clock, reset and enable.
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // Register port.
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DW-1:0] reg_rdata,
    // Field inputs.
    input wire bsup_pins_t pins,
    // Burner outputs.
    input wire logic blower_on,
    input wire logic burner_run,
    input wire logic motor_low,
    input wire logic warn,
    input wire logic lockout
);
    bsup_cfg_t cfg_r;
    logic [DW-1:0] tn_r;
    int both_r;
    int lim;
    logic req;
    logic lfs;
    // Settings are shadowed from the bus, since the checker cannot see inside.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_r <= bsup_cfg_t'(CFG_RST);
            tn_r <= T_NOCOMB_RST;
        end else if (ce && reg_wr && reg_addr == OFS_CFG) begin
            cfg_r <= bsup_cfg_t'(reg_wdata);
        end else if (ce && reg_wr && reg_addr == OFS_T_NOCOMB) begin
            tn_r <= reg_wdata;
        end
    end
    always_ff @(posedge mclk) begin
        both_r <= (sys_rst || !(pins.hi_fire && pins.lo_fire)) ? 0 : both_r + 1;
    end
    assign lim = (int'(tn_r) + 1) * TICK_CYCLES + 6;
    assign req = cfg_r.pilot_use ? pins.pilot_start : pins.start_req;
    assign lfs = cfg_r.pilot_use && cfg_r.lfs_en;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_stop;
        burner_run && !req;
    endsequence
    sequence s_freed;
        $past(pins.lock_reset, 3) || $past(pins.lock_reset, 4) || $past(pins.lock_reset, 5);
    endsequence
    chk_lock_hold: assert property ($fell(lockout) |-> s_freed)
        else $error("lockout left without reset");
    chk_lock_safe: assert property (lockout |-> !burner_run && !motor_low && !warn)
        else $error("outputs active in lockout");
    chk_both_fire: assert property (both_r == lim |-> lockout)
        else $error("no lockout with both fire switches on");
    chk_warn_mode: assert property (warn |-> cfg_r.tmo_mode == TMO_ALARM)
        else $error("warning outside alarm mode");
    chk_warn_step: assert property (warn |-> !burner_run)
        else $error("warning while running");
    chk_plain_stop: assert property (s_stop and !lfs |-> ##[1:6] !burner_run)
        else $error("burner not stopped promptly");
    chk_low_stop: assert property (s_stop and lfs && !pins.lo_fire
        |-> ##[1:6] (motor_low || lockout))
        else $error("motor not driven to low fire");
    chk_res_cont: assert property ($fell(blower_on) && !lockout && !$past(lockout)
        && cfg_r.res_mode == RES_CONT |-> !$past(pins.flame, 4))
        else $error("postpurge ended with flame present");
endmodule : bsup_chk

bind bsup_top bsup_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins),
    .blower_on(blower_on), .burner_run(burner_run), .motor_low(motor_low), .warn(warn),
    .lockout(lockout));

// *** verif/burner_sequence_supervisor_test.sv ***
`timescale 1ns/100ps
module burner_sequence_supervisor_test
    import bsup_pkg::*;
;
    localparam int TK = 4;
    localparam int TN = 10;
    localparam int TP = 5;
    localparam int TR = 20;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [AW-1:0] reg_addr = 8'h00;
    logic [DW-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DW-1:0] reg_rdata;
    logic hi = 1'b0, fl = 1'b0, pil = 1'b0, ans = 1'b0, sreq = 1'b0, lrst = 1'b0;
    logic air_hold = 1'b0;
    logic [1:0] lo_mode = 2'h0;
    logic air_sw, lo_fire;
    bsup_pins_t pins;
    logic [4:0] o;
    int n_errors = 0;
    int checked = 0;
    int n;
    logic [31:0] lfsr = 32'h855A3CD9;
    logic [AW-1:0] ofs [9] = '{OFS_CFG, OFS_T_NOCOMB, OFS_T_COMB, OFS_T_POST, OFS_T_LOPOST,
        OFS_T_REIGN, OFS_T_PREPURGE, OFS_STATUS, 8'h20};
    logic [DW-1:0] rv [9] = '{CFG_RST, T_NOCOMB_RST, T_COMB_RST, T_POST_RST, T_LOPOST_RST,
        T_REIGN_RST, T_PREPURGE_RST, 16'h0000, 16'h0000};
    assign pins = {hi, lo_fire, air_sw, fl, pil, ans, sreq, lrst};
    always #20 mclk = ~mclk;
    bsup_top #(.TICK_CYCLES(TK)) uut (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pins(pins), .blower_on(o[0]), .burner_run(o[1]),
        .motor_low(o[2]), .warn(o[3]), .lockout(o[4]));
    bsup_field u_fld (.mclk(mclk), .blower_on(o[0]), .motor_low(o[2]), .air_hold(air_hold),
        .lo_mode(lo_mode), .air_sw(air_sw), .lo_fire(lo_fire));
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : rnd
    task automatic stop_test();
        $display("Counts: %0d checked, %0d errors", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk) reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // Bounded wait on one output; running out of time ends the run.
    task automatic wt(input int b, input logic v, input int max, output int c);
        c = 0;
        #1;
        while (o[b] !== v && c < max) begin
            @(posedge mclk);
            #1;
            c++;
        end
        chk(o[b], v);
        if (o[b] !== v) begin
            stop_test();
        end
    endtask : wt
    task automatic cf(input bsup_tmo_t t, input bsup_rstm_t r, input logic lfs,
        input logic pu, input bsup_res_t rs, input logic an);
        bsup_cfg_t c;
        c = '0;
        c.tmo_mode = t;
        c.rst_mode = r;
        c.pp_en = 1'b1;
        c.pilot_use = pu;
        c.lfs_en = lfs;
        c.res_mode = rs;
        c.ans_en = an;
        wr(OFS_CFG, c);
    endtask : cf
    task automatic start();
        @(posedge mclk) pil <= 1'b1;
        wt(1, 1'b1, 400, n);
    endtask : start
    task automatic stop();
        @(posedge mclk) pil <= 1'b0;
        wt(0, 1'b0, 300, n);
    endtask : stop
    task automatic unlock();
        @(posedge mclk) pil <= 1'b0;
        repeat (20) @(posedge mclk);
        #1 chk(o[4], 1'b1);
        @(posedge mclk) lrst <= 1'b1;
        wt(4, 1'b0, 12, n);
        @(posedge mclk) lrst <= 1'b0;
        $display("Done: lockout cleared");
    endtask : unlock
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], rv[i]);
        lfsr = rnd(lfsr);
        wr(OFS_T_PREPURGE, lfsr[15:0]);
        rd(OFS_T_PREPURGE, lfsr[15:0]);
        wr(OFS_STATUS, 16'hFFFF);
        rd(OFS_STATUS, 16'h0000);
        wr(OFS_T_NOCOMB, TN);
        wr(OFS_T_COMB, TN);
        wr(OFS_T_POST, TP);
        wr(OFS_T_LOPOST, TP);
        wr(OFS_T_REIGN, TR);
        wr(OFS_T_PREPURGE, TP);
        $display("Done: registers");
        cf(TMO_WAIT, RST_CANCEL, 1'b0, 1'b1, RES_NONE, 1'b0);
        @(posedge mclk) air_hold <= 1'b1;
        @(posedge mclk) pil <= 1'b1;
        repeat ((TN + 3) * TK) @(posedge mclk);
        #1 chk(o[4:3], 2'h0);
        @(posedge mclk) air_hold <= 1'b0;
        wt(1, 1'b1, 400, n);
        @(posedge mclk) fl <= 1'b1;
        @(posedge mclk) pil <= 1'b0;
        wt(1, 1'b0, 8, n);
        wt(0, 1'b0, (TP + 1) * TK + 8, n);
        chk(n >= TP * TK - 2, 1'b1);
        @(posedge mclk) fl <= 1'b0;
        $display("Done: wait mode and plain stop");
        // Quick restarts come first, late ones after the reignition time.
        for (int k = 0; k < 6; k++) begin
            cf(TMO_WAIT, bsup_rstm_t'(k % 3), 1'b0, 1'b1, RES_NONE, 1'b0);
            start();
            stop();
            repeat (k < 3 ? 2 : (TR + 2) * TK) @(posedge mclk);
            @(posedge mclk) pil <= 1'b1;
            if (k == 5) begin
                wt(4, 1'b1, 40, n);
                unlock();
            end else begin
                wt(1, 1'b1, 400, n);
                chk(n > TP * TK, k == 0 || k >= 3);
                stop();
            end
        end
        $display("Done: restart options");
        for (int j = 0; j < 2; j++) begin
            cf(j ? TMO_LOCK : TMO_ALARM, RST_EVERY, 1'b0, 1'b1, RES_NONE, 1'b0);
            @(posedge mclk) air_hold <= 1'b1;
            @(posedge mclk) pil <= 1'b1;
            wt(j ? 4 : 3, 1'b1, (TN + 2) * TK + 12, n);
            chk(n >= TN * TK, 1'b1);
            @(posedge mclk) air_hold <= 1'b0;
            if (j) begin
                unlock();
            end else begin
                wt(3, 1'b0, 12, n);
                wt(1, 1'b1, 400, n);
                stop();
            end
        end
        $display("Done: timeout handling");
        cf(TMO_WAIT, RST_EVERY, 1'b1, 1'b1, RES_NONE, 1'b0);
        start();
        @(posedge mclk) pil <= 1'b0;
        wt(2, 1'b1, 10, n);
        chk(o[1], 1'b1);
        wt(1, 1'b0, 20, n);
        wt(0, 1'b0, 300, n);
        start();
        @(posedge mclk) lo_mode <= 2'h2;
        @(posedge mclk) pil <= 1'b0;
        wt(4, 1'b1, (TN + 2) * TK + 12, n);
        chk(n >= TN * TK, 1'b1);
        @(posedge mclk) lo_mode <= 2'h0;
        unlock();
        $display("Done: low fire stop");
        for (int r = 1; r < 4; r++) begin
            cf(TMO_WAIT, RST_EVERY, 1'b0, 1'b1, bsup_res_t'(r), 1'b0);
            start();
            @(posedge mclk) fl <= 1'b1;
            @(posedge mclk) pil <= 1'b0;
            wt(1, 1'b0, 8, n);
            if (r == 1) begin
                repeat ((TN + 3) * TK) @(posedge mclk);
                #1 chk(o[0], 1'b1);
                @(posedge mclk) fl <= 1'b0;
                wt(0, 1'b0, 10, n);
            end else begin
                wt(r == 3 ? 4 : 0, r == 3, (TN + 2) * TK + 12, n);
                chk(n >= TN * TK - 2, 1'b1);
                chk(o[4], r == 3);
                chk(o[0], 1'b0);
                @(posedge mclk) fl <= 1'b0;
                if (r == 3) begin
                    unlock();
                end
            end
        end
        $display("Done: residual flame");
        cf(TMO_WAIT, RST_EVERY, 1'b0, 1'b1, RES_NONE, 1'b0);
        start();
        @(posedge mclk) lo_mode <= 2'h1;
        hi <= 1'b1;
        wt(4, 1'b1, (TN + 2) * TK + 12, n);
        chk(n >= TN * TK, 1'b1);
        repeat (12) @(posedge mclk);
        @(posedge mclk) hi <= 1'b0;
        lo_mode <= 2'h0;
        unlock();
        cf(TMO_WAIT, RST_EVERY, 1'b1, 1'b0, RES_NONE, 1'b1);
        @(posedge mclk) sreq <= 1'b1;
        repeat (3 * TP * TK + 40) @(posedge mclk);
        #1 chk(o[1], 1'b0);
        @(posedge mclk) ans <= 1'b1;
        wt(1, 1'b1, (TP + 1) * TK + 20, n);
        @(posedge mclk) sreq <= 1'b0;
        wt(1, 1'b0, 8, n);
        $display("Done: fire switches and answerback");
        stop_test();
    end
endmodule : burner_sequence_supervisor_test
